// ===== hw/interrupt_enable_mask_low.sv
// low five interrupt enable bits with AXI4-Lite access
// assumes AXI4-Lite master on core_clk, flags held by sources
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_mask_low #(
    parameter int ADDR_W = irq_mask_pkg::ADDR_W
) (
    input  wire logic               core_clk,     // system clock
    input  wire logic               reset_n,      // async reset, low
    input  wire logic [ADDR_W-1:0]  awaddr,       // write address
    input  wire logic               awvalid,      // write address valid
    output var  logic               awready,      // write address ready
    input  wire logic [31:0]        wdata,        // write data
    input  wire logic [3:0]         wstrb,        // write byte strobes
    input  wire logic               wvalid,       // write data valid
    output var  logic               wready,       // write data ready
    output var  logic [1:0]         bresp,        // write response
    output var  logic               bvalid,       // write response valid
    input  wire logic               bready,       // write response ready
    input  wire logic [ADDR_W-1:0]  araddr,       // read address
    input  wire logic               arvalid,      // read address valid
    output var  logic               arready,      // read address ready
    output var  logic [31:0]        rdata,        // read data
    output var  logic [1:0]         rresp,        // read response
    output var  logic               rvalid,       // read data valid
    input  wire logic               rready,       // read data ready
    input  wire irq_mask_pkg::src_t pendingFlags, // source flags
    output var  irq_mask_pkg::src_t irqEnable,    // mask bits
    output var  irq_mask_pkg::src_t irqRequest    // gated requests
);

    // ****************************************************************
    // checks and decode
    // ****************************************************************
    if (ADDR_W < 4) begin : g_check
        $error("address too narrow for the register map");
    end

    function automatic irq_mask_pkg::sel_t regSel(
        input logic [ADDR_W-1:0] addr
    );
        logic [7:0] a;
        a = 8'(addr);
        if (ADDR_W > 8 && (addr >> 8) != '0) begin
            return irq_mask_pkg::SEL_NONE;
        end
        case (a)
            irq_mask_pkg::ADDR_ENABLE:  return irq_mask_pkg::SEL_ENABLE;
            irq_mask_pkg::ADDR_PENDING: return irq_mask_pkg::SEL_PENDING;
            irq_mask_pkg::ADDR_REQUEST: return irq_mask_pkg::SEL_REQUEST;
            default:                    return irq_mask_pkg::SEL_NONE;
        endcase
    endfunction

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rstN;

    reset_sync #(
        .STAGES (irq_mask_pkg::RESET_STAGES)
    ) u_reset_sync (
        .core_clk   (core_clk),
        .resetIn_n  (reset_n),
        .resetOut_n (rstN)
    );

    // ****************************************************************
    // state
    // ****************************************************************
    logic [4:0]        enableReg;
    logic              awHeldReg;
    logic              wHeldReg;
    logic [ADDR_W-1:0] awAddrReg;
    logic [31:0]       wDataReg;
    logic              wStrb0Reg;
    logic              bvalidReg;
    logic [1:0]        brespReg;
    logic              rvalidReg;
    logic [31:0]       rdataReg;
    logic [1:0]        rrespReg;
    logic              commit;
    logic              enableWrite;
    logic [4:0]        requestBits;

    irq_mask_pkg::sel_t wSel;
    irq_mask_pkg::sel_t rSel;

    assign wSel   = regSel(awAddrReg);
    assign rSel   = regSel(araddr);
    assign commit = awHeldReg && wHeldReg;
    assign enableWrite = commit && wSel == irq_mask_pkg::SEL_ENABLE
                         && wStrb0Reg;

    // ****************************************************************
    // write address and data capture, either order
    // ****************************************************************
    assign awready = !awHeldReg && !bvalidReg;
    assign wready  = !wHeldReg && !bvalidReg;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            awHeldReg <= 1'b0;
            awAddrReg <= '0;
        end else if (awvalid && awready) begin
            awHeldReg <= 1'b1;
            awAddrReg <= awaddr;
        end else if (commit) begin
            awHeldReg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            wHeldReg  <= 1'b0;
            wDataReg  <= '0;
            wStrb0Reg <= 1'b0;
        end else if (wvalid && wready) begin
            wHeldReg  <= 1'b1;
            wDataReg  <= wdata;
            wStrb0Reg <= wstrb[0];
        end else if (commit) begin
            wHeldReg <= 1'b0;
        end
    end

    // ****************************************************************
    // write response
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            bvalidReg <= 1'b0;
            brespReg  <= irq_mask_pkg::RESP_OKAY;
        end else if (commit) begin
            bvalidReg <= 1'b1;
            brespReg  <= (wSel == irq_mask_pkg::SEL_NONE)
                         ? irq_mask_pkg::RESP_SLVERR
                         : irq_mask_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalidReg <= 1'b0;
        end
    end

    assign bvalid = bvalidReg;
    assign bresp  = brespReg;

    // ****************************************************************
    // enable register, only software changes it
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            enableReg <= irq_mask_pkg::ENABLE_RESET;
        end else if (enableWrite) begin
            enableReg <= wDataReg[4:0];
        end
    end

    assign irqEnable = irq_mask_pkg::src_t'(enableReg);

    // ****************************************************************
    // gating of flags
    // ****************************************************************
    mask_gate #(
        .N (irq_mask_pkg::SRC_N)
    ) u_mask_gate (
        .flags    (pendingFlags),
        .enables  (enableReg),
        .requests (requestBits)
    );

    assign irqRequest = irq_mask_pkg::src_t'(requestBits);

    // ****************************************************************
    // read channel
    // ****************************************************************
    assign arready = !rvalidReg;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            rvalidReg <= 1'b0;
            rdataReg  <= '0;
            rrespReg  <= irq_mask_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalidReg <= 1'b1;
            rrespReg  <= irq_mask_pkg::RESP_OKAY;
            case (rSel)
                irq_mask_pkg::SEL_ENABLE: begin
                    rdataReg <= {27'h0, enableReg};
                end
                irq_mask_pkg::SEL_PENDING: begin
                    rdataReg <= {27'h0, pendingFlags};
                end
                irq_mask_pkg::SEL_REQUEST: begin
                    rdataReg <= {27'h0, requestBits};
                end
                default: begin
                    rdataReg <= '0;
                    rrespReg <= irq_mask_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalidReg <= 1'b0;
        end
    end

    assign rvalid = rvalidReg;
    assign rdata  = rdataReg;
    assign rresp  = rrespReg;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (!rstN);

    property p_serial_off;
        enableWrite && !wDataReg[irq_mask_pkg::SERIAL_IRQ_ENABLE_BIT]
        |=> !irqRequest.serial;
    endproperty
    a_serial_off: assert property (p_serial_off)
        else $error("serial request passed while disabled");

    property p_timer1_on;
        enableWrite && wDataReg[irq_mask_pkg::TIMER1_IRQ_ENABLE_BIT]
        ##1 pendingFlags.timer1 |-> irqRequest.timer1;
    endproperty
    a_timer1_on: assert property (p_timer1_on)
        else $error("timer 1 request blocked while enabled");

    property p_ext1_off;
        !irqEnable.ext1 [*2] |-> !irqRequest.ext1;
    endproperty
    a_ext1_off: assert property (p_ext1_off)
        else $error("external request 1 passed while disabled");

    property p_timer0_follow;
        enableWrite |=>
            irqEnable.timer0 ==
            $past(wDataReg[irq_mask_pkg::TIMER0_IRQ_ENABLE_BIT]);
    endproperty
    a_timer0_follow: assert property (p_timer0_follow)
        else $error("timer 0 enable did not take written value");

    property p_ext0_off;
        !irqEnable.ext0 |-> !irqRequest.ext0;
    endproperty
    a_ext0_off: assert property (p_ext0_off)
        else $error("external request 0 passed while disabled");

    property p_req_and;
        irqRequest == (pendingFlags & irqEnable);
    endproperty
    a_req_and: assert property (p_req_and)
        else $error("request differs from flag and mask");

    property p_mask_stable;
        !enableWrite |=> $stable(enableReg);
    endproperty
    a_mask_stable: assert property (p_mask_stable)
        else $error("mask changed without a write");

    property p_write_resp;
        commit |=> bvalid ##0 !awHeldReg ##0 !wHeldReg;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write response missing after both halves");

    property p_read_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read data dropped before taken");

    property p_write_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_write_hold: assert property (p_write_hold)
        else $error("write response dropped before taken");

    property p_bad_write_err;
        commit && wSel == irq_mask_pkg::SEL_NONE
        |=> bresp == irq_mask_pkg::RESP_SLVERR;
    endproperty
    a_bad_write_err: assert property (p_bad_write_err)
        else $error("unmapped write not refused");

    property p_busy_refuse;
        bvalid |-> !awready && !wready;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("write channel open while response pending");

    property p_enable_read;
        arvalid && arready && rSel == irq_mask_pkg::SEL_ENABLE
        |=> rdata == {27'h0, $past(enableReg)};
    endproperty
    a_enable_read: assert property (p_enable_read)
        else $error("enable read back differs from mask");

    property p_read_upper;
        rvalid |-> rdata[31:5] == 27'h0;
    endproperty
    a_read_upper: assert property (p_read_upper)
        else $error("unused read bits not zero");

endmodule
`default_nettype wire

// ===== hw/irq_mask_pkg.sv
// constants and types shared by the interrupt mask block
// assumes a single core clock domain and an AXI4-Lite master
package irq_mask_pkg;

    // ****************************************************************
    // sources, one bit each, order matches the mask bits
    // ****************************************************************
    typedef struct packed {
        logic serial;
        logic timer1;
        logic ext1;
        logic timer0;
        logic ext0;
    } src_t;

    localparam int SRC_N = 5;

    localparam int SERIAL_IRQ_ENABLE_BIT   = 4;
    localparam int TIMER1_IRQ_ENABLE_BIT   = 3;
    localparam int EXT_REQUEST1_ENABLE_BIT = 2;
    localparam int TIMER0_IRQ_ENABLE_BIT   = 1;
    localparam int EXT_REQUEST0_ENABLE_BIT = 0;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 8;

    localparam logic [7:0] ADDR_ENABLE  = 8'h00;
    localparam logic [7:0] ADDR_PENDING = 8'h04;
    localparam logic [7:0] ADDR_REQUEST = 8'h08;

    localparam logic [4:0] ENABLE_RESET = 5'h00;

    typedef enum logic [1:0] {
        SEL_ENABLE,
        SEL_PENDING,
        SEL_REQUEST,
        SEL_NONE
    } sel_t;

    // ****************************************************************
    // bus answers
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int RESET_STAGES = 2;

endpackage

// ===== hw/reset_sync.sv
// two-stage release of the asynchronous reset
// assumes resetIn_n may drop at any time, releases on the clock
`timescale 1ns/10ps
`default_nettype none
module reset_sync #(
    parameter int STAGES = irq_mask_pkg::RESET_STAGES
) (
    input  wire logic core_clk,    // system clock
    input  wire logic resetIn_n,   // raw reset, active low
    output var  logic resetOut_n   // released copy, active low
);

    logic [STAGES-1:0] stageReg;

    if (STAGES < 2) begin : g_check
        $error("reset_sync needs at least two stages");
    end

    // ****************************************************************
    // release pipe
    // ****************************************************************
    always_ff @(posedge core_clk or negedge resetIn_n) begin
        if (!resetIn_n) begin
            stageReg <= '0;
        end else begin
            stageReg <= {stageReg[STAGES-2:0], 1'b1};
        end
    end

    assign resetOut_n = stageReg[STAGES-1];

endmodule
`default_nettype wire

// ===== hw/mask_gate.sv
// per-source gating of pending flags by enable bits
// assumes flags are held by their sources until serviced
`timescale 1ns/10ps
`default_nettype none
module mask_gate #(
    parameter int N = irq_mask_pkg::SRC_N
) (
    input  wire logic [N-1:0] flags,    // pending flags
    input  wire logic [N-1:0] enables,  // mask bits
    output var  logic [N-1:0] requests  // gated requests
);

    if (N < 1) begin : g_check
        $error("mask_gate needs at least one source");
    end

    // ****************************************************************
    // one AND per source
    // ****************************************************************
    for (genvar i = 0; i < N; i++) begin : g_gate
        assign requests[i] = flags[i] & enables[i];
    end

endmodule
`default_nettype wire

// ===== tb/irq_source_model.sv
// interrupt sources on the far side: flags held until serviced
// assumes the bench pulses raise and service for single cycles
`timescale 1ns/10ps
`default_nettype none
module irq_source_model (
    input  wire logic               core_clk,     // system clock
    input  wire logic               reset_n,      // async reset, low
    input  wire irq_mask_pkg::src_t raise,        // set flags
    input  wire irq_mask_pkg::src_t service,      // clear flags
    output var  irq_mask_pkg::src_t pendingFlags  // held flags
);
    // ****************************************************************
    // sticky flags, cleared only by service, never by the mask
    // ****************************************************************
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pendingFlags <= '0;
        end else begin
            pendingFlags <= (pendingFlags | raise) & ~service;
        end
    end
endmodule
`default_nettype wire

// ===== tb/interrupt_enable_mask_low_tb.sv
// self-checking bench for the low interrupt enable mask
// assumes AXI4-Lite access on core_clk and the source model
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_mask_low_tb;
    logic               core_clk, reset_n;
    logic [7:0]         awaddr, araddr;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp;
    logic               awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready;
    irq_mask_pkg::src_t pendingFlags, irqEnable, irqRequest, raise, service;
    int                 badCount, cmpCount, i;

    interrupt_enable_mask_low i_dut (
        .core_clk, .reset_n, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .pendingFlags, .irqEnable, .irqRequest
    );

    irq_source_model i_src (
        .core_clk, .reset_n, .raise, .service, .pendingFlags
    );

    always #10 core_clk = ~core_clk;

    // ****************************************************************
    // compare and bus tasks
    // ****************************************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] ex);
        cmpCount++;
        if (got !== ex) begin
            badCount++;
            $display("CHECK FAILED t=%0t word %h exp %h", $time, got, ex);
        end
    endtask

    task automatic chk_src(input irq_mask_pkg::src_t got,
                           input irq_mask_pkg::src_t ex);
        cmpCount++;
        if (got !== ex) begin
            badCount++;
            $display("CHECK FAILED t=%0t src %h exp %h", $time, got, ex);
        end
    endtask

    // handshakes seen at the falling edge, taken at the next rising one;
    // ready follows valid by one cycle so the slave's hold is exercised
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] er);
        logic ta, tw, tb, tv;
        tb = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!tb) begin
            @(negedge core_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tv = bvalid;
            tb = bvalid && bready;
            if (tb) chk_word({30'h0, bresp}, {30'h0, er});
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            else if (tv) bready <= 1'b1;
        end
        @(posedge core_clk);
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                       input logic [1:0] er);
        logic ta, tr, tv;
        tr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!tr) begin
            @(negedge core_clk);
            ta = arvalid && arready;
            tv = rvalid;
            tr = rvalid && rready;
            if (tr) begin
                chk_word(rdata, ed);
                chk_word({30'h0, rresp}, {30'h0, er});
            end
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            else if (tv) rready <= 1'b1;
        end
        @(posedge core_clk);
    endtask

    task automatic set_flags(input irq_mask_pkg::src_t v);
        raise <= v;
        service <= ~v;
        @(posedge core_clk);
        raise <= '0;
        service <= '0;
        @(posedge core_clk);
        chk_src(pendingFlags, v);
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (2000) @(posedge core_clk);
        badCount++;
        finish_test;
    end

    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        raise = '0;
        service = '0;
        badCount = 0;
        cmpCount = 0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk_src(irqEnable, 5'h00);
        axr(irq_mask_pkg::ADDR_ENABLE, 32'h0, irq_mask_pkg::RESP_OKAY);
        set_flags(5'h1f);
        for (i = 0; i < 5; i++) begin
            axw(irq_mask_pkg::ADDR_ENABLE, 32'h1 << i, 4'hf,
                irq_mask_pkg::RESP_OKAY);
            chk_src(irqRequest, 5'(5'h01 << i));
            axr(irq_mask_pkg::ADDR_REQUEST, 32'h1 << i,
                irq_mask_pkg::RESP_OKAY);
        end
        axw(irq_mask_pkg::ADDR_ENABLE, 32'hffff_ffe0, 4'hf,
            irq_mask_pkg::RESP_OKAY);
        chk_src(irqRequest, 5'h00);
        $display("test single_bit_gating done");

        axw(irq_mask_pkg::ADDR_ENABLE, 32'h1f, 4'hf, irq_mask_pkg::RESP_OKAY);
        set_flags(5'h0a);
        chk_src(irqRequest, 5'h0a);
        axw(irq_mask_pkg::ADDR_ENABLE, 32'h05, 4'hf, irq_mask_pkg::RESP_OKAY);
        chk_src(pendingFlags, 5'h0a);
        chk_src(irqRequest, 5'h00);
        axr(irq_mask_pkg::ADDR_PENDING, 32'h0a, irq_mask_pkg::RESP_OKAY);
        set_flags(5'h15);
        chk_src(irqRequest, 5'h05);
        $display("test flags_kept done");

        axw(8'h0c, 32'h1f, 4'hf, irq_mask_pkg::RESP_SLVERR);
        axw(irq_mask_pkg::ADDR_PENDING, 32'h1f, 4'hf, irq_mask_pkg::RESP_OKAY);
        axw(irq_mask_pkg::ADDR_ENABLE, 32'h1f, 4'he, irq_mask_pkg::RESP_OKAY);
        chk_src(irqEnable, 5'h05);
        axr(irq_mask_pkg::ADDR_PENDING, 32'h15, irq_mask_pkg::RESP_OKAY);
        axr(8'h0c, 32'h0, irq_mask_pkg::RESP_SLVERR);
        $display("test bus_refusals done");
        finish_test;
    end
endmodule
`default_nettype wire
